// file: pkg/pev_pkg.sv
// Package of register offsets, field positions and reset values for pev block
//--------------------------------------------------------------------------
//--------------------------------------------------------------------------
package pev_pkg;

  //--------------------------------------------------------------------------
  // Register indices, byte address is index times four (printed offsets are register indices)
  //--------------------------------------------------------------------------
  localparam logic [7:0] IDX_ENABLE = 8'h12;
  localparam logic [7:0] IDX_STATUS = 8'h13;
  localparam logic [7:0] IDX_CONFIG = 8'h14;
  localparam logic [7:0] IDX_INT_STATUS = 8'h20;
  localparam logic [7:0] IDX_INT_CLEAR  = 8'h21;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h22;
  localparam int         ADDR_W = 10;

  //--------------------------------------------------------------------------
  // Event status fields
  //--------------------------------------------------------------------------
  localparam int BIT_NEG_ERR   = 15;
  localparam int BIT_SPEED     = 14;
  localparam int BIT_DUPLEX    = 13;
  localparam int BIT_PAGE      = 12;
  localparam int BIT_NEG_DONE  = 11;
  localparam int BIT_LINK      = 10;
  localparam int BIT_CARRIER   = 8;
  localparam int BIT_CROSS     = 6;
  localparam int BIT_FALLBACK  = 5;
  localparam int BIT_SLEEP     = 4;
  localparam int BIT_WAKE      = 3;
  localparam int BIT_MAC_ERR   = 2;
  localparam int BIT_POLARITY  = 1;
  localparam int BIT_JABBER    = 0;
  localparam logic [15:0] EVENT_MASK = 16'hfd7f;   // Bits 9 and 7 reserved

  //--------------------------------------------------------------------------
  // Configuration fields and reset values
  //--------------------------------------------------------------------------
  localparam int BIT_INT_POL   = 13;
  localparam int BIT_ATT_HI    = 11;
  localparam int BIT_ATT_LO    = 10;
  localparam int BIT_FB_EN     = 9;
  localparam int BIT_FB_ENERGY = 8;
  localparam int BIT_SER_NEG   = 7;
  localparam int BIT_FB_TEN    = 6;
  localparam logic [15:0] CONFIG_RW_MASK = 16'h2fc0;
  localparam logic [15:0] CONFIG_RESET   = 16'h29c7;
  localparam logic [5:0]  CONFIG_RSVD_LO = 6'h07;
  localparam logic [15:0] ENABLE_RESET   = 16'h0000;

  //--------------------------------------------------------------------------
  // Block interrupt events (sticky bits of the int status register)
  //--------------------------------------------------------------------------
  localparam int IRQ_W          = 2;
  localparam int IRQ_STATUS_SET = 0;   // Any event bit newly latched
  localparam int IRQ_FALLBACK   = 1;   // Fallback stepped down
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PEV_FB_GIGA = 3'h1,
    PEV_FB_FAST = 3'h2,
    PEV_FB_TEN  = 3'h4
  } pev_speed_t;

endpackage

// file: pkg/pev_status_if.sv
// Interface carrying event, read and status signals to the status latch
`timescale 1ns/1ps
interface pev_status_if;
  logic [15:0] events;
  logic        read_pulse;
  logic [15:0] status;
  logic        new_set;

  modport core  (output events, output read_pulse, input status,
                 input new_set);
  modport latch (input events, input read_pulse, output status,
                 output new_set);
endinterface

// file: design/pev_status_latch.sv
// Sticky event status word cleared by read
`timescale 1ns/1ps
module pev_status_latch
  import pev_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  pev_status_if.latch st
);

  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic        new_reg;

  //--------------------------------------------------------------------------
  // Latch logic
  //--------------------------------------------------------------------------
  // Events set regardless of enable; a read clears only what it reported,
  // and a new event in the read cycle wins over the clear
  always_comb begin
    status_next = st.read_pulse ? 16'h0000 : status_reg;
    status_next = (status_next | st.events) & EVENT_MASK;
  end

  // Status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 16'h0000;
      new_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      new_reg    <= |(st.events & EVENT_MASK & ~status_reg);
    end
  end

  assign st.status  = status_reg;
  assign st.new_set = new_reg;

endmodule // pev_status_latch

// file: design/pev_top.sv
// Event status, interrupt pin and fallback configuration block
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module pev_top
  import pev_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event detector pulses, same clock
  input  wire logic [15:0] event_in,
  // Link attempt outcome, same clock
  input  wire logic        giga_fail,
  input  wire logic        fast_fail,
  input  wire logic        link_up,
  input  wire logic        energy_cd,
  // Device outputs
  output logic             phy_int_pin,
  output logic             fallback_enable,
  output logic             fallback_energy_mode_enable,
  output logic             serial_mac_negotiation_enable,
  output logic             fallback_to_ten_enable,
  output logic [1:0]       fallback_attempt_count,
  output logic [2:0]       speed_mask,
  output logic             irq
);

  //--------------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------------
  pev_status_if st ();

  logic [15:0]      event_enable_reg;
  logic [15:0]      config_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear;
  logic             aw_held_reg;
  logic             w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             wr_go;
  logic             rd_go;
  logic             status_read;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic             wr_hit;
  logic [3:0]       fail_cnt_reg;
  logic [3:0]       fail_limit;
  pev_speed_t       speed_reg;
  logic             fb_pulse;
  logic             pend;

  // Decode a byte address into a register index match
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
  endfunction

  // Attempt count field to number of failed attempts
  function automatic logic [3:0] attempts(input logic [1:0] f);
    unique case (f)
      2'h0: attempts = 4'h1;
      2'h1: attempts = 4'h2;
      2'h2: attempts = 4'h4;
      2'h3: attempts = 4'h8;
    endcase
  endfunction

  //--------------------------------------------------------------------------
  // Status latch
  //--------------------------------------------------------------------------
  assign st.events     = event_in;
  assign st.read_pulse = status_read;

  pev_status_latch u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .st      (st)
  );

  //--------------------------------------------------------------------------
  // AXI4-Lite write path
  //--------------------------------------------------------------------------
  // Address and data are taken in either order; response once both held
  assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= '0;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_reg   <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_reg && !s_axi_bvalid;
    end
  end

  assign wr_hit = hit(aw_addr_reg, IDX_ENABLE) ||
                  hit(aw_addr_reg, IDX_STATUS) ||
                  hit(aw_addr_reg, IDX_CONFIG) ||
                  hit(aw_addr_reg, IDX_INT_STATUS) ||
                  hit(aw_addr_reg, IDX_INT_CLEAR) ||
                  hit(aw_addr_reg, IDX_INT_ENABLE);

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //--------------------------------------------------------------------------
  // Registers written by software
  //--------------------------------------------------------------------------
  // Event enable, reserved positions stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_enable_reg <= ENABLE_RESET;
    end else if (wr_go && hit(aw_addr_reg, IDX_ENABLE)) begin
      if (w_strb_reg[0])
        event_enable_reg[7:0]  <= w_data_reg[7:0] & EVENT_MASK[7:0];
      if (w_strb_reg[1])
        event_enable_reg[15:8] <= w_data_reg[15:8] & EVENT_MASK[15:8];
    end
  end

  // Configuration word: only writable fields take write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_go && hit(aw_addr_reg, IDX_CONFIG)) begin
      if (w_strb_reg[0])
        config_reg[7:6]  <= w_data_reg[7:6];
      if (w_strb_reg[1])
        config_reg[15:8] <= w_data_reg[15:8] & CONFIG_RW_MASK[15:8];
    end
  end

  // Block interrupt enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg <= '0;
    end else if (wr_go && hit(aw_addr_reg, IDX_INT_ENABLE) && w_strb_reg[0])
    begin
      irq_enable_reg <= w_data_reg[IRQ_W-1:0];
    end
  end

  //--------------------------------------------------------------------------
  // AXI4-Lite read path
  //--------------------------------------------------------------------------
  assign rd_go       = s_axi_arvalid && s_axi_arready;
  assign status_read = rd_go && hit(s_axi_araddr, IDX_STATUS);

  // Read data; status write is a silent no-op, clear reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (hit(s_axi_araddr, IDX_ENABLE))
      rd_word[15:0] = event_enable_reg;
    else if (hit(s_axi_araddr, IDX_STATUS))
      rd_word[15:0] = st.status;
    else if (hit(s_axi_araddr, IDX_CONFIG))
      rd_word[15:0] = {config_reg[15:6], CONFIG_RSVD_LO};
    else if (hit(s_axi_araddr, IDX_INT_STATUS))
      rd_word[IRQ_W-1:0] = irq_status_reg;
    else if (hit(s_axi_araddr, IDX_INT_ENABLE))
      rd_word[IRQ_W-1:0] = irq_enable_reg;
    else if (!hit(s_axi_araddr, IDX_INT_CLEAR))
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // Speed fallback sequencer
  //--------------------------------------------------------------------------
  // Counts failed gigabit attempts, then steps down to 100 and 10 Mb/s
  assign fail_limit = attempts(config_reg[BIT_ATT_HI:BIT_ATT_LO]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_reg    <= PEV_FB_GIGA;
      fail_cnt_reg <= 4'h0;
      fb_pulse     <= 1'b0;
    end else begin
      fb_pulse <= 1'b0;
      if (link_up || !config_reg[BIT_FB_EN]) begin
        if (!config_reg[BIT_FB_EN]) speed_reg <= PEV_FB_GIGA;
        fail_cnt_reg <= 4'h0;
      end else begin
        unique case (speed_reg)
          PEV_FB_GIGA: begin
            if (config_reg[BIT_FB_ENERGY] && !energy_cd) begin
              speed_reg <= PEV_FB_FAST;
              fb_pulse  <= 1'b1;
            end else if (giga_fail) begin
              if (fail_cnt_reg + 4'h1 >= fail_limit) begin
                speed_reg    <= PEV_FB_FAST;
                fail_cnt_reg <= 4'h0;
                fb_pulse     <= 1'b1;
              end else begin
                fail_cnt_reg <= fail_cnt_reg + 4'h1;
              end
            end
          end
          PEV_FB_FAST: begin
            if (fast_fail && config_reg[BIT_FB_TEN]) begin
              speed_reg <= PEV_FB_TEN;
              fb_pulse  <= 1'b1;
            end
          end
          PEV_FB_TEN: begin
            speed_reg <= PEV_FB_TEN;
          end
          default: speed_reg <= PEV_FB_GIGA;
        endcase
      end
    end
  end

  //--------------------------------------------------------------------------
  // Block interrupt: sticky status, write-one-to-clear, enable
  //--------------------------------------------------------------------------
  assign irq_set   = {fb_pulse, st.new_set};
  assign irq_clear = (wr_go && hit(aw_addr_reg, IDX_INT_CLEAR) &&
                      w_strb_reg[0]) ? w_data_reg[IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_status_reg <= '0;
    else
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
  end

  //--------------------------------------------------------------------------
  // Output registers
  //--------------------------------------------------------------------------
  // Pin active while any enabled event is pending; polarity per config
  assign pend = |(st.status & event_enable_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_int_pin                   <= 1'b1;   // Inactive level, active low
      irq                           <= 1'b0;
      fallback_enable               <= 1'b0;
      fallback_energy_mode_enable   <= 1'b1;
      serial_mac_negotiation_enable <= 1'b1;
      fallback_to_ten_enable        <= 1'b1;
      fallback_attempt_count        <= 2'h2;
      speed_mask                    <= PEV_FB_GIGA;
    end else begin
      phy_int_pin <= pend ^ config_reg[BIT_INT_POL];
      irq         <= |(irq_status_reg & irq_enable_reg);
      fallback_enable               <= config_reg[BIT_FB_EN];
      fallback_energy_mode_enable   <= config_reg[BIT_FB_ENERGY];
      serial_mac_negotiation_enable <= config_reg[BIT_SER_NEG];
      fallback_to_ten_enable        <= config_reg[BIT_FB_TEN];
      fallback_attempt_count <= config_reg[BIT_ATT_HI:BIT_ATT_LO];
      speed_mask                    <= speed_reg;
    end
  end

endmodule // pev_top

// file: verif/pev_top_assertions.sv
// Checker of bus answers, reset values and fallback outputs
`timescale 1ns/1ps
module pev_top_assertions
  import pev_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        energy_cd,
  input wire logic        phy_int_pin,
  input wire logic        fallback_enable,
  input wire logic        fallback_energy_mode_enable,
  input wire logic        serial_mac_negotiation_enable,
  input wire logic        fallback_to_ten_enable,
  input wire logic [1:0]  fallback_attempt_count,
  input wire logic [2:0]  speed_mask
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------
  // Bus answers
  // ----------
  sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_r_held; s_axi_rvalid && $stable(s_axi_rdata); endsequence
  property p_rd_answer; s_ar_taken |=> s_axi_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_r_held; endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped early");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped early");
  // ----------
  // Reset and fallback
  // ----------
  // Reset is sampled low here, so the reset term must not disable it
  property p_reset;
    disable iff (1'b0) !aresetn |=> phy_int_pin && speed_mask == 3'h1
      && fallback_attempt_count == 2'h2 && !fallback_enable
      && fallback_energy_mode_enable && serial_mac_negotiation_enable
      && fallback_to_ten_enable;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset values wrong");
  property p_onehot; $onehot(speed_mask); endproperty
  a_onehot: assert property (p_onehot)
    else $error("speed mask not one-hot");
  property p_giga; (!fallback_enable) [*3] |-> speed_mask == 3'h1; endproperty
  a_giga: assert property (p_giga)
    else $error("fallback while disabled");
  sequence s_no_energy;
    fallback_enable && fallback_energy_mode_enable && !energy_cd;
  endsequence
  property p_energy; s_no_energy [*3] |-> speed_mask != 3'h1; endproperty
  a_energy: assert property (p_energy)
    else $error("no fallback without energy");
  property p_ten;
    $rose(speed_mask[2]) |-> fallback_to_ten_enable && fallback_enable;
  endproperty
  a_ten: assert property (p_ten)
    else $error("ten step while forbidden");
endmodule // pev_top_assertions

bind pev_top pev_top_assertions i_chk (.*);

// file: verif/pev_host_model.sv
// Host model: register bus master of the management controller
`timescale 1ns/1ps
module pev_host_model (
  input  wire logic        aclk,
  output logic [9:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [9:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      r = bresp;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a; // Released lines must not keep the last value
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // Read: hold the request until taken, the ready until answered
  task automatic rd(input logic [9:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      d = rdata;
      r = rresp;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule // pev_host_model

// file: verif/phy_event_status_and_speed_fallback_cfg_test.sv
// Self-checking bench of the event status and speed fallback block
`timescale 1ns/1ps
module phy_event_status_and_speed_fallback_cfg_test
  import pev_pkg::*;
;
  localparam logic [9:0] A_EN = {IDX_ENABLE, 2'h0};
  localparam logic [9:0] A_ST = {IDX_STATUS, 2'h0};
  localparam logic [9:0] A_CF = {IDX_CONFIG, 2'h0};
  localparam logic [9:0] A_IS = {IDX_INT_STATUS, 2'h0};
  localparam logic [9:0] A_IC = {IDX_INT_CLEAR, 2'h0};
  localparam logic [9:0] A_IE = {IDX_INT_ENABLE, 2'h0};
  logic        aclk, aresetn, giga_fail, fast_fail, link_up, energy_cd;
  logic [15:0] event_in, en;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, phy_int_pin, irq;
  logic        fallback_enable, fallback_energy_mode_enable;
  logic        serial_mac_negotiation_enable, fallback_to_ten_enable;
  logic [1:0]  fallback_attempt_count;
  logic [2:0]  speed_mask;
  logic [33:0] q_exp[$], q_msk[$], e_v, m_v;
  int          err_total, compares, cycles, seed, n;

  pev_top i_dut (.*);
  pev_host_model i_host (
    .aclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
    .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
    .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready)
  );
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // ----------
  // Helpers
  // ----------
  task automatic check(input string nm, input logic [33:0] s,
                       input logic [33:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Let launched updates land before outputs are looked at
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  task automatic pulse(input logic [15:0] ev, input logic g = 1'b0,
                       input logic f = 1'b0, input logic l = 1'b0);
    @(posedge aclk);
    event_in <= ev;
    giga_fail <= g;
    fast_fail <= f;
    link_up <= l;
    @(posedge aclk);
    event_in <= '0;
    {giga_fail, fast_fail, link_up} <= '0;
  endtask
  // Note the expected answer, then read; the monitor compares
  task automatic rdx(input logic [9:0] a, input logic [31:0] e,
                     input logic [1:0] er = AXI_OKAY,
                     input logic [33:0] m = {34{1'b1}});
    q_exp.push_back({er, e});
    q_msk.push_back(m);
    i_host.rd(a, d, r);
  endtask
  task automatic wrx(input logic [9:0] a, input logic [31:0] v,
                     input logic [1:0] er = AXI_OKAY);
    i_host.wr(a, v, r);
    check("bresp", 34'(r), 34'(er));
  endtask
  function automatic logic [33:0] cfg_o();
    return 34'({fallback_enable, fallback_energy_mode_enable,
                serial_mac_negotiation_enable, fallback_to_ten_enable,
                fallback_attempt_count});
  endfunction
  // Oldest note is taken off whenever a read answer is accepted
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      e_v = q_exp.pop_front();
      m_v = q_msk.pop_front();
      check("rdata", {s_axi_rresp, s_axi_rdata} & m_v, e_v & m_v);
    end
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // ----------
  // Scenarios
  // ----------
  initial begin
    {aclk, aresetn, giga_fail, fast_fail, link_up} = '0;
    event_in = '0;
    energy_cd = 1'b1;
    seed = 64;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdx(A_CF, 32'h29c7);
    rdx(A_EN, 32'h0);
    rdx(A_ST, 32'h0);
    $display("test reset done");
    // Each source alone, reserved places stay clear, reads clear
    for (int i = 0; i < 16; i++) begin
      pulse(16'h1 << i);
      rdx(A_ST, 32'(EVENT_MASK & (16'h1 << i)));
      rdx(A_ST, 32'h0);
    end
    pulse(16'h1);
    wrx(A_ST, 32'hffff);
    rdx(A_ST, 32'h1);
    check("pin", 34'(phy_int_pin), 34'h1);
    wrx(A_CF, 32'hffffffff);
    rdx(A_CF, 32'h2fc7);
    check("cfg", cfg_o(), 34'h3f);
    wrx(A_CF, 32'h0);
    rdx(A_CF, 32'h7);
    check("cfg", cfg_o(), 34'h0);
    check("pin", 34'(phy_int_pin), 34'h0);
    $display("test status and config done");
    // Pin follows enabled bits only, in both polarities
    en = 16'($random(seed)) & EVENT_MASK | 16'h0400;
    wrx(A_EN, 32'(en));
    rdx(A_EN, 32'(en));
    pulse(~en & EVENT_MASK);
    settle(2);
    check("pin", 34'(phy_int_pin), 34'h0);
    rdx(A_ST, 32'(~en & EVENT_MASK));
    pulse(16'h0400);
    settle(4);
    check("pin", 34'(phy_int_pin), 34'h1);
    rdx(A_ST, 32'h400);
    settle(2);
    check("pin", 34'(phy_int_pin), 34'h0);
    wrx(A_CF, 32'h2000);
    pulse(16'h0400);
    settle(2);
    check("pin", 34'(phy_int_pin), 34'h0);
    rdx(A_ST, 32'h400);
    // Event on the very edge that takes the read is kept
    settle(3);
    fork
      rdx(A_ST, 32'h0);
      pulse(16'h2);
    join
    rdx(A_ST, 32'h2);
    $display("test pin done");
    // Every attempt code; a link in between restarts the count
    for (int c = 0; c < 4; c++) begin
      n = 1 << c;
      wrx(A_CF, 32'h20c0);
      wrx(A_CF, 32'h22c0 | 32'(c << 10));
      if (n > 1) begin
        pulse(16'h0, 1'b1);
        pulse(16'h0, 1'b0, 1'b0, 1'b1);
      end
      repeat (n - 1) pulse(16'h0, 1'b1);
      settle(3);
      check("speed", 34'(speed_mask), 34'h1);
      pulse(16'h0, 1'b1);
      settle(3);
      check("speed", 34'(speed_mask), 34'h2);
    end
    pulse(16'h0, 1'b0, 1'b1);
    settle(3);
    check("speed", 34'(speed_mask), 34'h4);
    wrx(A_CF, 32'h20c0);
    wrx(A_CF, 32'h2280);
    pulse(16'h0, 1'b1);
    pulse(16'h0, 1'b0, 1'b1);
    settle(3);
    check("speed", 34'(speed_mask), 34'h2);
    wrx(A_CF, 32'h20c0);
    wrx(A_CF, 32'h23c0);
    @(posedge aclk);
    energy_cd <= 1'b0;
    settle(3);
    check("speed", 34'(speed_mask), 34'h2);
    @(posedge aclk);
    energy_cd <= 1'b1;
    wrx(A_CF, 32'h20c0);
    $display("test fallback done");
    // Block interrupt: raise, mask, clear, refused address
    rdx(A_ST, 32'h0, AXI_OKAY, 34'h0);
    wrx(A_IC, 32'h3);
    wrx(A_IE, 32'h1);
    rdx(A_IS, 32'h0);
    pulse(16'h1);
    settle(2);
    check("irq", 34'(irq), 34'h1);
    rdx(A_IS, 32'h1);
    wrx(A_IE, 32'h0);
    settle(2);
    check("irq", 34'(irq), 34'h0);
    wrx(A_IE, 32'h1);
    wrx(A_IC, 32'h1);
    settle(2);
    check("irq", 34'(irq), 34'h0);
    rdx(A_IC, 32'h0);
    wrx(10'h3fc, 32'h1, AXI_SLVERR);
    rdx(10'h3fc, 32'h0, AXI_SLVERR, {2'h3, 32'h0});
    settle(4);
    $display("test irq done");
    give_verdict();
  end
endmodule // phy_event_status_and_speed_fallback_cfg_test
